//--- prom_cell_model.sv
// Behavioural 256 x 8 erasable PROM seen from its programming pins.
// Assumes logic pin levels: a low data pin stands for the -48V level.
`timescale 1ns/1ps
`default_nettype none
module prom_cell_model (
    input wire logic [7:0] prom_addr,
    input wire logic [7:0] prom_data,
    input wire logic prom_data_oe,
    input wire logic pulsed_gate_supply,
    input wire logic drain_supply,
    input wire logic prog_pulse,
    input wire logic [7:0] rd_addr,
    output logic [7:0] rd_data
);
    logic [7:0] cells [256];
    initial begin
        foreach (cells[i]) cells[i] = 8'h00;
    end
    // No clock on the part; the pulse edge itself writes the word
    always @(posedge prog_pulse) begin
        if (pulsed_gate_supply && drain_supply && prom_data_oe) begin
            // Bits only ever gain ones, all eight at once
            cells[prom_addr] = cells[prom_addr] | ~prom_data;
        end
    end
    assign rd_data = cells[rd_addr];
endmodule // prom_cell_model
`default_nettype wire

//--- prom_phase_timer.sv
// Down-counting phase timer for the programming sequencer.
// Assumes load is a single-cycle strobe from the sequencer.
`timescale 1ns/1ps
`default_nettype none
module prom_phase_timer #(
    parameter int WIDTH = 20
) (
    input wire logic ref_clk,
    input wire logic rst,
    input wire logic load,
    input wire logic [WIDTH-1:0] load_val,
    output logic expired
);
    typedef struct packed {
        logic [WIDTH-1:0] count;
        logic expired;
    } timer_state_t;

    timer_state_t r_reg;
    timer_state_t r_next;

    always_comb begin
        r_next = r_reg;
        if (load) begin
            r_next.count = load_val;
            r_next.expired = 1'b0;
        end else if (r_reg.count != '0) begin
            r_next.count = r_reg.count - 1'b1;
        end else begin
            r_next.expired = 1'b1;
        end
    end

    always_ff @(posedge ref_clk or posedge rst) begin
        if (rst) begin
            r_reg <= '0;
        end else begin
            r_reg <= r_next;
        end
    end

    assign expired = r_reg.expired;
endmodule // prom_phase_timer
`default_nettype wire

//--- prom_prog_pkg.sv
// Constants for the PROM programming controller.
// Assumes a 20 MHz reference clock; times are minimums unless noted.
// Function
// - All address bits complemented when pulsed supplies swing negative.
// - Complemented address held 25 us after both supplies are negative.
// - True address applied at least 10 us before the program pulse.
// - Addresses stepped 0 through 255, whole pass repeated at least 32 times.
// - Data pins act as inputs; programmer drives the word pattern onto them.
// - Data pin at low programming level stores one; high leaves zero.
// - Gate supply, drain supply and program input are pulses, not levels.
package prom_prog_pkg;
    localparam int CLK_PERIOD_NS = 50;
    localparam int T_ACW_US = 25;
    localparam int T_ACH_US = 25;
    localparam int T_VW_US = 100;
    localparam int T_ATW_US = 10;
    localparam int T_VD_US = 10;
    localparam int T_PW_US = 3000;
    localparam int DUTY_PCT = 20;
    localparam int NUM_WORDS = 256;
    localparam int NUM_PASSES = 32;
    // Least times round up
    localparam int T_ACW_CYC = (T_ACW_US * 1000 + CLK_PERIOD_NS - 1)
        / CLK_PERIOD_NS;
    localparam int T_ACH_CYC = (T_ACH_US * 1000 + CLK_PERIOD_NS - 1)
        / CLK_PERIOD_NS;
    localparam int T_VW_CYC = (T_VW_US * 1000 + CLK_PERIOD_NS - 1)
        / CLK_PERIOD_NS;
    localparam int T_ATW_CYC = (T_ATW_US * 1000 + CLK_PERIOD_NS - 1)
        / CLK_PERIOD_NS;
    localparam int T_VD_CYC = (T_VD_US * 1000 + CLK_PERIOD_NS - 1)
        / CLK_PERIOD_NS;
    // Longest time rounds down
    localparam int T_PW_CYC = (T_PW_US * 1000) / CLK_PERIOD_NS;
    // True-address phase also stretches supply setup before the pulse
    localparam int T_TRUE_CYC = (T_VW_CYC - T_ACH_CYC > T_ATW_CYC) ?
        (T_VW_CYC - T_ACH_CYC) : T_ATW_CYC;
    localparam int TIMER_W = 20;
    typedef enum logic [3:0] {
        ST_IDLE, ST_LOAD, ST_COMP, ST_SUPPLY, ST_TRUE, ST_PROG, ST_HOLD,
        ST_REST, ST_DONE
    } prog_state_t;
endpackage

//--- prom_programmer.sv
// Programmer that writes a 256 x 8 erasable PROM, pass after pass.
// Assumes level shifters outside turn each logic pin into its supply level;
// a logic low on an address or data pin is the negative programming level.
`timescale 1ns/1ps
`default_nettype none
module prom_programmer
    import prom_prog_pkg::*;
#(
    parameter int PW_CYC = T_PW_CYC,
    parameter int DUTY = DUTY_PCT,
    parameter int PASSES = NUM_PASSES,
    // Fewer words only to shorten simulation; hardware uses the full array
    parameter int WORDS = NUM_WORDS
) (
    input wire logic ref_clk,
    input wire logic rst,
    input wire logic start,
    input wire logic [7:0] word_data,
    output logic [7:0] word_addr,
    output logic busy,
    output logic done,
    output logic [6:0] pass_count,
    output logic [7:0] prom_addr,
    output logic [7:0] prom_data,
    output logic prom_data_oe,
    output logic pulsed_gate_supply,
    output logic drain_supply,
    output logic prog_pulse
);
    // Supply off-time keeps on-time within the duty-cycle limit
    localparam int ON_CYC = T_ACH_CYC + T_TRUE_CYC + PW_CYC + T_VD_CYC;
    localparam int REST_CYC = (ON_CYC * (100 - DUTY) + DUTY - 1) / DUTY;

    typedef struct packed {
        prog_state_t st;
        logic [7:0] addr;
        logic [6:0] pass;
        logic [7:0] word;
        logic [7:0] addr_pins;
        logic [7:0] data_pins;
        logic data_oe;
        logic supply_on;
        logic prog_on;
        logic busy;
        logic done;
        logic [TIMER_W-1:0] sup_cnt;
        logic [TIMER_W-1:0] true_cnt;
        logic pulsed;
    } prog_reg_t;

    prog_reg_t r_reg;
    prog_reg_t r_next;
    logic tmr_load;
    logic [TIMER_W-1:0] tmr_val;
    logic tmr_done;

    prom_phase_timer #(.WIDTH(TIMER_W)) phase_timer (
        .ref_clk(ref_clk),
        .rst(rst),
        .load(tmr_load),
        .load_val(tmr_val),
        .expired(tmr_done)
    );

    always_comb begin
        r_next = r_reg;
        tmr_load = 1'b0;
        tmr_val = '0;
        case (r_reg.st)
            ST_IDLE, ST_DONE: begin
                if (start) begin
                    r_next.st = ST_LOAD;
                    r_next.addr = 8'h00;
                    r_next.pass = 7'h00;
                    r_next.busy = 1'b1;
                    r_next.done = 1'b0;
                end
            end
            ST_LOAD: begin
                // Word for the current address is taken here
                r_next.word = word_data;
                r_next.data_pins = ~word_data;
                r_next.data_oe = 1'b1;
                r_next.addr_pins = ~r_reg.addr;
                tmr_load = 1'b1;
                tmr_val = TIMER_W'(T_ACW_CYC);
                r_next.st = ST_COMP;
            end
            ST_COMP: begin
                if (tmr_done) begin
                    r_next.supply_on = 1'b1;
                    tmr_load = 1'b1;
                    tmr_val = TIMER_W'(T_ACH_CYC);
                    r_next.st = ST_SUPPLY;
                end
            end
            ST_SUPPLY: begin
                if (tmr_done) begin
                    r_next.addr_pins = r_reg.addr;
                    tmr_load = 1'b1;
                    tmr_val = TIMER_W'(T_TRUE_CYC);
                    r_next.st = ST_TRUE;
                end
            end
            ST_TRUE: begin
                if (tmr_done) begin
                    // All eight bits go in one pulse
                    r_next.prog_on = 1'b1;
                    tmr_load = 1'b1;
                    tmr_val = TIMER_W'(PW_CYC - 1);
                    r_next.st = ST_PROG;
                end
            end
            ST_PROG: begin
                if (tmr_done) begin
                    r_next.prog_on = 1'b0;
                    tmr_load = 1'b1;
                    tmr_val = TIMER_W'(T_VD_CYC);
                    r_next.st = ST_HOLD;
                end
            end
            ST_HOLD: begin
                if (tmr_done) begin
                    r_next.supply_on = 1'b0;
                    r_next.data_oe = 1'b0;
                    tmr_load = 1'b1;
                    tmr_val = TIMER_W'(REST_CYC);
                    r_next.st = ST_REST;
                end
            end
            ST_REST: begin
                if (tmr_done) begin
                    // One pulse per address, then ascend
                    r_next.addr = r_reg.addr + 8'h01;
                    r_next.st = ST_LOAD;
                    if (r_reg.addr == 8'(WORDS - 1)) begin
                        r_next.addr = 8'h00;
                        r_next.pass = r_reg.pass + 7'h01;
                        if (r_reg.pass == 7'(PASSES - 1)) begin
                            r_next.st = ST_DONE;
                            r_next.busy = 1'b0;
                            r_next.done = 1'b1;
                        end
                    end
                end
            end
            default: begin
                r_next.st = ST_IDLE;
            end
        endcase
        // Helper counts for the checks below
        r_next.sup_cnt = !r_reg.supply_on ? '0 :
            (&r_reg.sup_cnt ? r_reg.sup_cnt : r_reg.sup_cnt + 1'b1);
        r_next.true_cnt = (r_reg.addr_pins != r_reg.addr) ? '0 :
            (&r_reg.true_cnt ? r_reg.true_cnt : r_reg.true_cnt + 1'b1);
        if (r_next.addr != r_reg.addr) begin
            r_next.pulsed = 1'b0;
        end else if (r_reg.prog_on) begin
            r_next.pulsed = 1'b1;
        end
    end

    always_ff @(posedge ref_clk or posedge rst) begin
        if (rst) begin
            r_reg <= '0;
            r_reg.st <= ST_IDLE;
        end else begin
            r_reg <= r_next;
        end
    end

    assign word_addr = r_reg.addr;
    assign busy = r_reg.busy;
    assign done = r_reg.done;
    assign pass_count = r_reg.pass;
    assign prom_addr = r_reg.addr_pins;
    assign prom_data = r_reg.data_pins;
    assign prom_data_oe = r_reg.data_oe;
    assign pulsed_gate_supply = r_reg.supply_on;
    assign drain_supply = r_reg.supply_on;
    assign prog_pulse = r_reg.prog_on;

    addr_complement_a: assert property (@(posedge ref_clk) disable iff (rst)
        $rose(pulsed_gate_supply) |-> prom_addr == ~word_addr)
        else $error("address not complemented at supply swing");
    complement_hold_a: assert property (@(posedge ref_clk) disable iff (rst)
        $rose(prom_addr == word_addr) && pulsed_gate_supply
        |-> r_reg.sup_cnt >= TIMER_W'(T_ACH_CYC))
        else $error("complemented address held too briefly");
    true_setup_a: assert property (@(posedge ref_clk) disable iff (rst)
        $rose(prog_pulse) |-> r_reg.true_cnt >= TIMER_W'(T_ATW_CYC))
        else $error("true address too late before program pulse");
    addr_ascend_a: assert property (@(posedge ref_clk) disable iff (rst)
        busy && $changed(word_addr) |-> word_addr ==
        (($past(word_addr) == 8'(WORDS - 1)) ? 8'h00 :
        $past(word_addr) + 8'h01))
        else $error("address not stepped upward by one");
    pass_total_a: assert property (@(posedge ref_clk) disable iff (rst)
        $rose(done) |-> pass_count == 7'(PASSES))
        else $error("wrong number of passes");
    data_driven_a: assert property (@(posedge ref_clk) disable iff (rst)
        prog_pulse |-> prom_data_oe && prom_data == ~r_reg.word)
        else $error("data pattern not driven during pulse");
    pulse_in_supply_a: assert property (@(posedge ref_clk) disable iff (rst)
        $fell(prog_pulse) |-> pulsed_gate_supply && drain_supply
        ##1 pulsed_gate_supply [*8])
        else $error("program pulse outside supply pulse");
    one_pulse_a: assert property (@(posedge ref_clk) disable iff (rst)
        $rose(prog_pulse) |-> !r_reg.pulsed)
        else $error("second program pulse at one address");
endmodule // prom_programmer
`default_nettype wire

//--- tb.sv
// Self-checking bench: programmer writes a random image into the model.
// Assumes PW_CYC 4, DUTY 100, 16 words and two passes to keep the run short.
`timescale 1ns/1ps
`default_nettype none
module tb;
    localparam int NP = 2;
    localparam int NW = 16;
    logic ref_clk, rst, start, busy, done, prom_data_oe;
    logic pulsed_gate_supply, drain_supply, prog_pulse, gate_prev, prog_prev;
    logic [7:0] word_data, word_addr, prom_addr, prom_data, rd_addr, rd_data;
    logic [7:0] cur, addr_prev;
    logic [6:0] pass_count;
    logic [7:0] pat [256];
    logic [7:0] exp_q [$];
    int n_errors, samples_checked, comp_cnt, true_cnt, pulses;

    prom_programmer #(.PW_CYC(4), .DUTY(100), .PASSES(NP), .WORDS(NW)) dut (
        .ref_clk(ref_clk), .rst(rst), .start(start), .word_data(word_data),
        .word_addr(word_addr), .busy(busy), .done(done),
        .pass_count(pass_count), .prom_addr(prom_addr),
        .prom_data(prom_data), .prom_data_oe(prom_data_oe),
        .pulsed_gate_supply(pulsed_gate_supply),
        .drain_supply(drain_supply), .prog_pulse(prog_pulse)
    );
    prom_cell_model prom (
        .prom_addr(prom_addr), .prom_data(prom_data),
        .prom_data_oe(prom_data_oe),
        .pulsed_gate_supply(pulsed_gate_supply),
        .drain_supply(drain_supply), .prog_pulse(prog_pulse),
        .rd_addr(rd_addr), .rd_data(rd_data)
    );

    task automatic check(input logic [7:0] seen, input logic [7:0] want);
        samples_checked++;
        if (seen !== want) begin
            n_errors++;
            $display("unexpected at %0t: saw %h wanted %h", $time, seen, want);
        end
    endtask

    task automatic final_report;
        if (n_errors == 0 && samples_checked > 0) begin
            $display("*** PASS ***");
        end else begin
            $display("*** FAIL ***");
        end
        $finish;
    endtask

    initial begin
        ref_clk = 1'b0;
        forever #25 ref_clk = ~ref_clk;
    end

    // Lookup answered half a cycle after word_addr moves
    always @(negedge ref_clk) word_data <= pat[word_addr];

    initial begin
        rst = 1'b1;
        start = 1'b0;
        word_data = 8'h00;
        rd_addr = 8'h00;
        {gate_prev, prog_prev, addr_prev} = 10'h000;
        {n_errors, samples_checked, comp_cnt, true_cnt, pulses} = '0;
        void'($urandom(32'hFFD4));
        foreach (pat[i]) pat[i] = 8'($urandom);
        pat[0] = 8'h00;
        pat[NW-1] = 8'hFF;
        for (int p = 0; p < NP; p++) begin
            for (int w = 0; w < NW; w++) exp_q.push_back(8'(w));
        end
        repeat (20) @(posedge ref_clk);
        @(negedge ref_clk) rst = 1'b0;
        @(negedge ref_clk) start = 1'b1;
        @(negedge ref_clk) start = 1'b0;
        // A second start mid-run must not disturb the sequence
        repeat (3000) @(negedge ref_clk);
        start = 1'b1;
        @(negedge ref_clk) start = 1'b0;
        for (int i = 0; i < 97000 && done !== 1'b1; i++) begin
            @(negedge ref_clk);
        end
        @(negedge ref_clk);
        check(8'(pass_count), 8'(NP));
        check(8'(busy), 8'h00);
        check(8'(exp_q.size()), 8'h00);
        for (int w = 0; w < 256; w++) begin
            rd_addr = 8'(w);
            #1;
            check(rd_data, w < NW ? pat[w] : 8'h00);
        end
        final_report;
    end

    // Sampled mid-cycle so outputs have settled
    always @(negedge ref_clk) begin
        if (!rst) begin
            if (pulsed_gate_supply && !gate_prev) begin
                cur = exp_q.size() > 0 ? exp_q[0] : 8'hXX;
                check(prom_addr, ~cur);
                check(prom_data, ~pat[cur]);
                check(8'(drain_supply & prom_data_oe), 8'h01);
                comp_cnt = 0;
                pulses = 0;
            end
            if (pulsed_gate_supply && prom_addr !== addr_prev) begin
                check(8'(comp_cnt >= 500), 8'h01);
                true_cnt = 0;
            end
            if (prog_pulse && !prog_prev) begin
                cur = exp_q.size() > 0 ? exp_q.pop_front() : 8'hXX;
                check(8'(true_cnt >= 200), 8'h01);
                check(prom_addr, cur);
                pulses++;
            end
            if (!pulsed_gate_supply && gate_prev) begin
                check(8'(pulses), 8'h01);
                check(8'(prog_pulse | drain_supply), 8'h00);
            end
            comp_cnt++;
            true_cnt++;
            gate_prev = pulsed_gate_supply;
            prog_prev = prog_pulse;
            addr_prev = prom_addr;
        end
    end

    // Two passes of 16 words take about 87k cycles
    initial begin
        repeat (99000) @(posedge ref_clk);
        n_errors++;
        final_report;
    end
endmodule // tb
`default_nettype wire
